// ### include/tsc_map.vh
/*
 * Register map and constants of the temperature sensor register bank.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TSC_MAP_VH
`define TSC_MAP_VH

// pointer locations
`define TSC_PTR_CAPABILITY    8'h00
`define TSC_PTR_CONFIG        8'h01
`define TSC_PTR_UPPER         8'h02
`define TSC_PTR_LOWER         8'h03
`define TSC_PTR_CRITICAL      8'h04
`define TSC_PTR_TEMPERATURE   8'h05
`define TSC_PTR_MAKER_ID      8'h06
`define TSC_PTR_PART_ID       8'h07
`define TSC_PTR_RESET         8'h00

// capability word
`define TSC_CAPABILITY_VALUE  16'h0015
`define TSC_CAP_ALARM_BIT     0
`define TSC_CAP_ACCURACY_BIT  1
`define TSC_CAP_RANGE_BIT     2
`define TSC_CAP_RES_LSB       3
`define TSC_CAP_RES_MSB       4

// configuration word
`define TSC_CFG_RESET         16'h0000
`define TSC_CFG_MODE_BIT      0
`define TSC_CFG_POLARITY_BIT  1
`define TSC_CFG_CRITONLY_BIT  2
`define TSC_CFG_EVT_EN_BIT    3
`define TSC_CFG_EVT_STAT_BIT  4
`define TSC_CFG_EVT_CLR_BIT   5
`define TSC_CFG_AWLOCK_BIT    6
`define TSC_CFG_CTLOCK_BIT    7
`define TSC_CFG_SHUTDOWN_BIT  8
`define TSC_CFG_HYST_LSB      9
`define TSC_CFG_HYST_MSB      10

// boundary and temperature words
`define TSC_BOUND_RESET       13'h0000
`define TSC_BOUND_MSB         12
`define TSC_TEMP_BELOW_BIT    13
`define TSC_TEMP_ABOVE_BIT    14
`define TSC_TEMP_CRIT_BIT     15

// hysteresis in 0.125 degree counts
`define TSC_HYST_SEL_NONE     2'h0
`define TSC_HYST_SEL_1P5      2'h1
`define TSC_HYST_SEL_3        2'h2
`define TSC_HYST_SEL_6        2'h3
`define TSC_HYST_NONE         13'h0000
`define TSC_HYST_1P5          13'h000C
`define TSC_HYST_3            13'h0018
`define TSC_HYST_6            13'h0030

`endif

// ### hw/tsc_window.v
/*
 * One hysteretic threshold flag: above-bound or below-bound comparator.
 * Assumes signed readings and bounds in 0.125 degree counts, hysteresis
 * as a positive count, and an update pulse per fresh reading.
 */
`timescale 1ns/10ps
`default_nettype none

module tsc_window #(
    parameter WIDTH    = 12,
    parameter IS_UPPER = 1
) (
    // clock and reset
    input  wire                     clock,
    input  wire                     rst_n,
    // comparison inputs
    input  wire                     update,
    input  wire signed [WIDTH-1:0]  reading,
    input  wire signed [WIDTH-1:0]  bound,
    input  wire        [WIDTH-1:0]  hyst,
    // flag
    output reg                      flag
);

    wire signed [WIDTH+1:0] ext_reading;
    wire signed [WIDTH+1:0] ext_bound;
    wire signed [WIDTH+1:0] release_pt;
    reg                     next_flag;

    assign ext_reading = {{2{reading[WIDTH-1]}}, reading};
    assign ext_bound   = {{2{bound[WIDTH-1]}}, bound};
    assign release_pt  = ext_bound - $signed({2'b00, hyst});

    always @* begin
        next_flag = flag;
        if (update) begin
            if (IS_UPPER != 0) begin
                if (!flag && ext_reading > ext_bound)
                    next_flag = 1'b1;
                else if (flag && ext_reading <= release_pt)
                    next_flag = 1'b0;
            end else begin
                if (ext_reading >= ext_bound)
                    next_flag = 1'b0;
                else if (ext_reading <= release_pt)
                    next_flag = 1'b1;
            end
        end
    end

    always @(posedge clock) begin
        if (!rst_n)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end

endmodule

`default_nettype wire

// ### hw/tsc_regs.v
/*
 * Capability and configuration register bank of a temperature sensor,
 * with alarm window and critical comparators and the event output.
 * Assumes a serial bus engine that presents pointer writes, register
 * writes and takes read data, and a converter that delivers readings.
 */
//
// Behaviour
// - capability word at pointer 00h is read-only; writes change nothing
// - capability bits 15:5 always read zero
// - capability resolution field bits 4:3 reads binary 10
// - capability bit 2 reads 1, sub-zero readings supported
// - capability bit 1 accuracy grade reads 0
// - capability bit 0 reads 1, alarm and critical events supported
// - configuration bits 15:11 read zero; configuration resets to zero
// - configuration bits 10:9 select hysteresis none, 1.5, 3 or 6 degrees
// - above flag sets when reading strictly exceeds upper bound
// - above flag clears when reading at or below upper minus hysteresis
// - below flag is zero while reading at or above lower bound
// - below flag sets when reading at or below lower minus hysteresis
// - event output uses the same hysteresis thresholds as the flags
// - hysteresis field unchanged by writes while either lock is set
// - configuration bit 8 shuts the sensor down; zero runs it
// - no temperature events while shut down
// - setting shutdown is ignored while either lock is set
// - clearing shutdown works regardless of the locks
// - bit 7 critical lock, bit 6 window lock; stick until reset
`timescale 1ns/10ps
`default_nettype none
`include "tsc_map.vh"

module tsc_regs #(
    parameter [15:0] MAKER_ID = 16'h5A5A,
    parameter [15:0] PART_ID  = 16'h0101
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst_n,
    // register access from the bus engine
    input  wire         ptr_wr,
    input  wire  [7:0]  ptr_value,
    input  wire         reg_wr,
    input  wire  [15:0] reg_wdata,
    output reg   [15:0] rd_data,
    // converter side
    input  wire         temp_valid,
    input  wire  [11:0] temp_reading,
    output wire         sensor_shutdown,
    // event side
    output wire         event_active,
    output wire         event_polarity,
    output wire         event_mode_select
);

    // MAKER_ID and PART_ID values are arbitrary

    ////////////////////////////////////////////////////////////////////
    // stored state

    reg  [7:0]  pointer;
    reg  [1:0]  hysteresis_select;
    reg         shutdown_bit;
    reg         critical_trip_lock;
    reg         alarm_window_lock;
    reg         event_output_enable;
    reg         critical_only_select;
    reg         polarity_bit;
    reg         mode_bit;
    reg  [12:0] upper_bound;
    reg  [12:0] lower_bound;
    reg  [12:0] critical_bound;
    reg  [11:0] temp_latched;

    wire        any_lock;
    wire        wr_config;
    wire        wr_upper;
    wire        wr_lower;
    wire        wr_critical;
    wire        take_reading;
    wire        above_flag;
    wire        below_flag;
    wire        critical_flag;
    wire        event_asserted_flag;
    wire        window_event;
    wire        selected_event;
    wire [15:0] capability_word;
    wire [15:0] config_word;
    wire [15:0] temp_word;
    reg  [12:0] hyst_counts;
    reg  [15:0] next_rd_data;

    assign any_lock     = critical_trip_lock | alarm_window_lock;
    assign wr_config    = reg_wr && (pointer == `TSC_PTR_CONFIG);
    assign wr_upper     = reg_wr && (pointer == `TSC_PTR_UPPER);
    assign wr_lower     = reg_wr && (pointer == `TSC_PTR_LOWER);
    assign wr_critical  = reg_wr && (pointer == `TSC_PTR_CRITICAL);
    assign take_reading = temp_valid && !shutdown_bit;

    ////////////////////////////////////////////////////////////////////
    // pointer
    // pointer holds its value until the next pointer load

    always @(posedge clock) begin
        if (!rst_n)
            pointer <= `TSC_PTR_RESET;
        else if (ptr_wr)
            pointer <= ptr_value;
    end

    ////////////////////////////////////////////////////////////////////
    // configuration register
    // lock state before the write decides, so a locking write lands in full
    // polarity and mode stored only; the event pin stays active high

    always @(posedge clock) begin
        if (!rst_n) begin
            hysteresis_select    <= `TSC_HYST_SEL_NONE;
            shutdown_bit         <= 1'b0;
            critical_trip_lock   <= 1'b0;
            alarm_window_lock    <= 1'b0;
            event_output_enable  <= 1'b0;
            critical_only_select <= 1'b0;
            polarity_bit         <= 1'b0;
            mode_bit             <= 1'b0;
        end else if (wr_config) begin
            if (!any_lock) begin
                hysteresis_select <= reg_wdata[`TSC_CFG_HYST_MSB:`TSC_CFG_HYST_LSB];
                event_output_enable  <= reg_wdata[`TSC_CFG_EVT_EN_BIT];
                critical_only_select <= reg_wdata[`TSC_CFG_CRITONLY_BIT];
            end
            if (!reg_wdata[`TSC_CFG_SHUTDOWN_BIT])
                shutdown_bit <= 1'b0;
            else if (!any_lock)
                shutdown_bit <= 1'b1;
            if (reg_wdata[`TSC_CFG_CTLOCK_BIT])
                critical_trip_lock <= 1'b1;
            if (reg_wdata[`TSC_CFG_AWLOCK_BIT])
                alarm_window_lock <= 1'b1;
            polarity_bit <= reg_wdata[`TSC_CFG_POLARITY_BIT];
            mode_bit     <= reg_wdata[`TSC_CFG_MODE_BIT];
        end
    end

    assign sensor_shutdown   = shutdown_bit;
    assign event_polarity    = polarity_bit;
    assign event_mode_select = mode_bit;

    ////////////////////////////////////////////////////////////////////
    // boundary registers
    // window bounds held by the window lock, critical bound by its own

    always @(posedge clock) begin
        if (!rst_n) begin
            upper_bound    <= `TSC_BOUND_RESET;
            lower_bound    <= `TSC_BOUND_RESET;
            critical_bound <= `TSC_BOUND_RESET;
        end else begin
            if (wr_upper && !alarm_window_lock)
                upper_bound <= reg_wdata[`TSC_BOUND_MSB:0];
            if (wr_lower && !alarm_window_lock)
                lower_bound <= reg_wdata[`TSC_BOUND_MSB:0];
            if (wr_critical && !critical_trip_lock)
                critical_bound <= reg_wdata[`TSC_BOUND_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reading latch
    // readings offered during shutdown are dropped

    always @(posedge clock) begin
        if (!rst_n)
            temp_latched <= 12'h000;
        else if (take_reading)
            temp_latched <= temp_reading;
    end

    ////////////////////////////////////////////////////////////////////
    // hysteresis selection
    // whole reading counts, so no fractional step is needed

    always @* begin
        case (hysteresis_select)
            `TSC_HYST_SEL_1P5: hyst_counts = `TSC_HYST_1P5;
            `TSC_HYST_SEL_3:   hyst_counts = `TSC_HYST_3;
            `TSC_HYST_SEL_6:   hyst_counts = `TSC_HYST_6;
            default:           hyst_counts = `TSC_HYST_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // window and critical comparators
    // critical trip shares the window hysteresis

    tsc_window #(
        .WIDTH    (12),
        .IS_UPPER (1)
    ) u_above (
        .clock   (clock),
        .rst_n   (rst_n),
        .update  (take_reading),
        .reading (temp_reading),
        .bound   (upper_bound[12:1]),
        .hyst    (hyst_counts[11:0]),
        .flag    (above_flag)
    );

    tsc_window #(
        .WIDTH    (12),
        .IS_UPPER (0)
    ) u_below (
        .clock   (clock),
        .rst_n   (rst_n),
        .update  (take_reading),
        .reading (temp_reading),
        .bound   (lower_bound[12:1]),
        .hyst    (hyst_counts[11:0]),
        .flag    (below_flag)
    );

    tsc_window #(
        .WIDTH    (12),
        .IS_UPPER (1)
    ) u_critical (
        .clock   (clock),
        .rst_n   (rst_n),
        .update  (take_reading),
        .reading (temp_reading),
        .bound   (critical_bound[12:1]),
        .hyst    (hyst_counts[11:0]),
        .flag    (critical_flag)
    );

    ////////////////////////////////////////////////////////////////////
    // event output

    assign window_event        = above_flag | below_flag | critical_flag;
    assign selected_event      = critical_only_select ? critical_flag : window_event;
    assign event_asserted_flag = event_output_enable && !shutdown_bit &&
                                 selected_event;
    assign event_active = event_asserted_flag;

    ////////////////////////////////////////////////////////////////////
    // read words

    assign capability_word = `TSC_CAPABILITY_VALUE;

    assign config_word = {5'h00,
                          hysteresis_select,
                          shutdown_bit,
                          critical_trip_lock,
                          alarm_window_lock,
                          1'b0,
                          event_asserted_flag,
                          event_output_enable,
                          critical_only_select,
                          polarity_bit,
                          mode_bit};

    assign temp_word = {critical_flag,
                        above_flag,
                        below_flag,
                        temp_latched,
                        1'b0};

    ////////////////////////////////////////////////////////////////////
    // read data mux
    // unmapped pointers read zero; rd_data trails the pointer by a cycle

    always @* begin
        if (pointer == `TSC_PTR_CAPABILITY)
            next_rd_data = capability_word;
        else if (pointer == `TSC_PTR_CONFIG)
            next_rd_data = config_word;
        else if (pointer == `TSC_PTR_UPPER)
            next_rd_data = {3'h0, upper_bound};
        else if (pointer == `TSC_PTR_LOWER)
            next_rd_data = {3'h0, lower_bound};
        else if (pointer == `TSC_PTR_CRITICAL)
            next_rd_data = {3'h0, critical_bound};
        else if (pointer == `TSC_PTR_TEMPERATURE)
            next_rd_data = temp_word;
        else if (pointer == `TSC_PTR_MAKER_ID)
            next_rd_data = MAKER_ID;
        else if (pointer == `TSC_PTR_PART_ID)
            next_rd_data = PART_ID;
        else
            next_rd_data = 16'h0000;
    end

    always @(posedge clock) begin
        if (!rst_n)
            rd_data <= 16'h0000;
        else
            rd_data <= next_rd_data;
    end

endmodule

`default_nettype wire

// ### bench/tsc_regs_props.sv
/* checker of the register bank ports, bound from the bench top
   assumes one clock and a synchronous active low reset */
`timescale 1ns/10ps
`default_nettype none
module tsc_regs_props (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // register access
    input wire logic        ptr_wr,
    input wire logic [7:0]  ptr_value,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] rd_data,
    // converter and event
    input wire logic        temp_valid,
    input wire logic [11:0] temp_reading,
    input wire logic        sensor_shutdown,
    input wire logic        event_active,
    input wire logic        event_polarity,
    input wire logic        event_mode_select
);
    logic [7:0] cur_ptr;
    logic       locked;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // pointer and sticky lock shadow
    always @(posedge clock) begin
        if (!rst_n) begin
            cur_ptr <= 8'h00;
            locked  <= 1'b0;
        end else begin
            if (ptr_wr) begin
                cur_ptr <= ptr_value;
            end
            if (reg_wr && cur_ptr == 8'h01 && (reg_wdata[7] || reg_wdata[6])) begin
                locked <= 1'b1;
            end
        end
    end
    sequence cfg_write;
        reg_wr && cur_ptr == 8'h01;
    endsequence
    cap_word_a: assert property (cur_ptr == 8'h00 |=> rd_data == 16'h0015)
        else $error("capability word wrong");
    cfg_reset_a: assert property ($rose(rst_n) |-> !sensor_shutdown && !event_polarity)
        else $error("configuration not cleared by reset");
    shut_set_a: assert property (cfg_write and reg_wdata[8] && !locked |=> sensor_shutdown)
        else $error("shutdown not set");
    shut_lock_a: assert property (cfg_write and locked && !sensor_shutdown |=> !sensor_shutdown)
        else $error("shutdown set while locked");
    shut_clear_a: assert property (cfg_write and !reg_wdata[8] |=> !sensor_shutdown)
        else $error("shutdown not cleared");
    shut_quiet_a: assert property (sensor_shutdown |-> !event_active)
        else $error("event while shut down");
    lock_stick_a: assert property (locked && cur_ptr == 8'h01 |=> rd_data[7:6] != 2'b00)
        else $error("lock bit lost");
    event_status_a: assert property (cur_ptr == 8'h01 |=> rd_data[4] == $past(event_active))
        else $error("event status bit differs from event output");
endmodule
`default_nettype wire

// ### bench/tsc_host_model.sv
/* host model: bus engine side of the register bank
   assumes a free running clock; drives on falling edges */
`timescale 1ns/10ps
`default_nettype none
module tsc_host_model (
    // clock
    input  wire logic        clock,
    // register access
    output var  logic        ptr_wr,
    output var  logic [7:0]  ptr_value,
    output var  logic        reg_wr,
    output var  logic [15:0] reg_wdata,
    input  wire logic [15:0] rd_data
);
    initial begin
        ptr_wr    = 1'b0;
        ptr_value = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
    end
    ////////////////////////////////////////
    // released lines show the inverse value
    task automatic set_ptr(input logic [7:0] addr);
        @(negedge clock);
        ptr_wr    = 1'b1;
        ptr_value = addr;
        @(negedge clock);
        ptr_wr    = 1'b0;
        ptr_value = ~addr;
    endtask
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        set_ptr(addr);
        reg_wr    = 1'b1;
        reg_wdata = data;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_wdata = ~data;
    endtask
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        set_ptr(addr);
        @(negedge clock);
        data = rd_data;
    endtask
endmodule
`default_nettype wire

// ### bench/test_temp_sensor_capability_config.sv
/* bench top: register bank, host model and checker bind
   assumes the host model tasks for all register traffic */
`timescale 1ns/10ps
`default_nettype none
module test_temp_sensor_capability_config;
    logic        clock;
    logic        rst_n;
    logic        temp_valid;
    logic [11:0] temp_reading;
    wire         ptr_wr;
    wire  [7:0]  ptr_value;
    wire         reg_wr;
    wire  [15:0] reg_wdata;
    wire  [15:0] rd_data;
    wire         sensor_shutdown;
    wire         event_active;
    wire         event_polarity;
    wire         event_mode_select;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          hyst [4] = '{0, 12, 24, 48};
    int          h;
    tsc_regs tsc_regs_i (.clock(clock), .rst_n(rst_n), .ptr_wr(ptr_wr),
        .ptr_value(ptr_value), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .rd_data(rd_data),
        .temp_valid(temp_valid), .temp_reading(temp_reading),
        .sensor_shutdown(sensor_shutdown), .event_active(event_active),
        .event_polarity(event_polarity), .event_mode_select(event_mode_select));
    tsc_host_model tsc_host_model_i (.clock(clock), .ptr_wr(ptr_wr), .ptr_value(ptr_value),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .rd_data(rd_data));
    ////////////////////////////////////////
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic expect_word(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] word;
        tsc_host_model_i.read_reg(addr, word);
        chk16("rd_data", exp, word);
    endtask
    task automatic feed(input logic [11:0] value, input logic exp);
        @(negedge clock);
        temp_valid   = 1'b1;
        temp_reading = value;
        @(negedge clock);
        temp_valid   = 1'b0;
        temp_reading = ~value;
        chk1("event_active", exp, event_active);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        $display("CHECK FAILED run expected done seen running");
        wrap_up();
    end
    initial begin
        rst_n        = 1'b0;
        temp_valid   = 1'b0;
        temp_reading = 12'h000;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        expect_word(8'h00, 16'h0015);
        expect_word(8'h01, 16'h0000);
        tsc_host_model_i.write_reg(8'h00, 16'hFFFF);
        expect_word(8'h00, 16'h0015);
        tsc_host_model_i.write_reg(8'h02, 16'h0100);
        tsc_host_model_i.write_reg(8'h03, 16'h0040);
        tsc_host_model_i.write_reg(8'h04, 16'h0FFE);
        // upper flag for every hysteresis selection
        for (h = 0; h < 4; h++) begin
            tsc_host_model_i.write_reg(8'h01, {5'h00, 2'(h), 9'h008});
            expect_word(8'h01, {5'h00, 2'(h), 9'h008});
            feed(12'd128, 1'b0);
            feed(12'd129, 1'b1);
            expect_word(8'h05, 16'h4102);
            feed(12'(129 - hyst[h]), 1'b1);
            feed(12'(128 - hyst[h]), 1'b0);
        end
        // lower flag, 6 degree hysteresis, crossing zero
        feed(12'd31, 1'b0);
        feed(12'hFF1, 1'b0);
        feed(12'hFF0, 1'b1);
        feed(12'd20, 1'b1);
        feed(12'd32, 1'b0);
        // critical only, critical bound 32 degrees
        tsc_host_model_i.write_reg(8'h04, 16'h0200);
        tsc_host_model_i.write_reg(8'h01, 16'h000C);
        feed(12'd200, 1'b0);
        feed(12'd257, 1'b1);
        expect_word(8'h05, 16'hC202);
        feed(12'd32, 1'b0);
        // shutdown and locks
        tsc_host_model_i.write_reg(8'h01, 16'h0108);
        chk1("sensor_shutdown", 1'b1, sensor_shutdown);
        feed(12'd200, 1'b0);
        tsc_host_model_i.write_reg(8'h01, 16'h0148);
        tsc_host_model_i.write_reg(8'h01, 16'h0040);
        chk1("sensor_shutdown", 1'b0, sensor_shutdown);
        expect_word(8'h01, 16'h0048);
        tsc_host_model_i.write_reg(8'h01, 16'h0703);
        chk1("sensor_shutdown", 1'b0, sensor_shutdown);
        expect_word(8'h01, 16'h004B);
        chk1("event_polarity", 1'b1, event_polarity);
        chk1("event_mode_select", 1'b1, event_mode_select);
        tsc_host_model_i.write_reg(8'h01, 16'h0000);
        tsc_host_model_i.write_reg(8'h02, 16'h0200);
        expect_word(8'h02, 16'h0100);
        feed(12'd200, 1'b1);
        expect_word(8'h01, 16'h0058);
        // second reset clears the locks
        @(negedge clock);
        rst_n = 1'b0;
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        expect_word(8'h01, 16'h0000);
        chk1("event_active", 1'b0, event_active);
        wrap_up();
    end
endmodule
bind tsc_regs tsc_regs_props tsc_regs_props_i (.clock(clock), .rst_n(rst_n),
    .ptr_wr(ptr_wr), .ptr_value(ptr_value), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .rd_data(rd_data), .temp_valid(temp_valid), .temp_reading(temp_reading),
    .sensor_shutdown(sensor_shutdown), .event_active(event_active),
    .event_polarity(event_polarity), .event_mode_select(event_mode_select));
`default_nettype wire
